/* src/input_clock_data_polarity.sv */
// Purpose: Polarity conditioning for the parallel and serial digital inputs.
// Assumes: Pins are asynchronous to mclk, the serial link pins included.
// Notes:   Internal clock mode captures parallel data on a divided tick.
//
// How it works
// - I clock sense held, applied, normal on reset.
// - I/Q clock sense only in parallel external.
// - I clock sense reads back as code.
// - Q clock sense held, applied, normal on reset.
// - Q clock sense reads back as code.
// - Serial clock sense held, applied, resets normal.
// - Serial senses matter only in serial mode.
// - Serial clock sense reads back as code.
// - Serial data sense inverts bits, resets normal.
// - Serial data sense reads back as code.
// - Global write sets every sense at once.
//
// Design decisions made here: the register offsets and strobed register access.

`timescale 1ns/100ps
`default_nettype none

module input_clock_data_polarity #(
  parameter int NIB_W   = polarity_pkg::NIBBLE_W,
  parameter int BYTE_W  = polarity_pkg::BYTE_W,
  parameter int INT_DIV = polarity_pkg::INT_DIV
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata_q,
  // Parallel input pins
  input  wire logic              i_clk_pin,
  input  wire logic              q_clk_pin,
  input  wire logic [NIB_W-1:0]  i_data_pin,
  input  wire logic [NIB_W-1:0]  q_data_pin,
  // Serial link pins
  input  wire logic              ser_clk,
  input  wire logic              ser_data_pin,
  // Conditioned data out
  output logic      [NIB_W-1:0]  i_word_q,
  output logic                   i_valid_q,
  output logic      [NIB_W-1:0]  q_word_q,
  output logic                   q_valid_q,
  output logic      [BYTE_W-1:0] ser_byte_q,
  output logic                   ser_valid_q
);

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  logic             serial_mode_q;
  logic             ext_clock_q;
  logic             i_clock_sense_q;
  logic             q_clock_sense_q;
  logic             ser_clock_sense_q;
  logic             ser_data_sense_q;
  logic             ser_frame_sense_q;
  logic [NIB_W-1:0] i_data_sense_q;
  logic [NIB_W-1:0] q_data_sense_q;
  logic             wr_mode;
  logic             wr_sense;
  logic             wr_global;
  logic             gsense;

  assign wr_mode   = reg_wr && (reg_addr == polarity_pkg::MODE_OFS);
  assign wr_sense  = reg_wr && (reg_addr == polarity_pkg::SENSE_OFS);
  assign wr_global = reg_wr && (reg_addr == polarity_pkg::GLOBAL_OFS);
  assign gsense    = reg_wdata[polarity_pkg::GLOBAL_SENSE_BIT];

  always_ff @(posedge mclk) begin
    if (reset) begin
      {ext_clock_q, serial_mode_q} <= polarity_pkg::MODE_RESET;
    end else if (wr_mode) begin
      serial_mode_q <= reg_wdata[polarity_pkg::MODE_SERIAL_BIT];
      ext_clock_q   <= reg_wdata[polarity_pkg::MODE_EXTCLK_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      i_clock_sense_q   <= polarity_pkg::SENSE_NORMAL;
      q_clock_sense_q   <= polarity_pkg::SENSE_NORMAL;
      ser_clock_sense_q <= polarity_pkg::SENSE_NORMAL;
      ser_data_sense_q  <= polarity_pkg::SENSE_NORMAL;
      ser_frame_sense_q <= polarity_pkg::SENSE_NORMAL;
      i_data_sense_q    <= polarity_pkg::NIBBLE_NORMAL;
      q_data_sense_q    <= polarity_pkg::NIBBLE_NORMAL;
    end else if (wr_global) begin
      // Burst and random-clock senses live elsewhere and stay untouched.
      i_clock_sense_q   <= gsense;
      q_clock_sense_q   <= gsense;
      ser_clock_sense_q <= gsense;
      ser_data_sense_q  <= gsense;
      ser_frame_sense_q <= gsense;
      i_data_sense_q    <= {NIB_W{gsense}};
      q_data_sense_q    <= {NIB_W{gsense}};
    end else if (wr_sense) begin
      i_clock_sense_q   <= reg_wdata[polarity_pkg::I_CLOCK_BIT];
      q_clock_sense_q   <= reg_wdata[polarity_pkg::Q_CLOCK_BIT];
      ser_clock_sense_q <= reg_wdata[polarity_pkg::SER_CLOCK_BIT];
      ser_data_sense_q  <= reg_wdata[polarity_pkg::SER_DATA_BIT];
      ser_frame_sense_q <= reg_wdata[polarity_pkg::SER_FRAME_BIT];
      i_data_sense_q    <= reg_wdata[polarity_pkg::I_DATA_LSB +: NIB_W];
      q_data_sense_q    <= reg_wdata[polarity_pkg::Q_DATA_LSB +: NIB_W];
    end
  end

  // ----------------------------------------------------------------------
  // Parallel inputs
  // ----------------------------------------------------------------------
  localparam int PW = 2 + 2 * NIB_W;
  localparam int DIV_W = $clog2(INT_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);

  logic [PW-1:0]    par_s;
  logic             iclk_s;
  logic             qclk_s;
  logic [NIB_W-1:0] idat_s;
  logic [NIB_W-1:0] qdat_s;
  logic             iclk_eff_q;
  logic             qclk_eff_q;
  logic             i_edge;
  logic             q_edge;
  logic             par_ext;
  logic [DIV_W-1:0] div_q;
  logic             tick_q;

  sync_two_ff #(.WIDTH(PW)) u_par_sync (
    .clk      (mclk),
    .in_async ({i_clk_pin, q_clk_pin, i_data_pin, q_data_pin}),
    .out_sync (par_s)
  );

  assign {iclk_s, qclk_s, idat_s, qdat_s} = par_s;
  assign par_ext = !serial_mode_q && ext_clock_q;

  // An inverted clock turns a falling pin edge into the capture edge.
  always_ff @(posedge mclk) begin
    if (reset) begin
      iclk_eff_q <= 1'b0;
      qclk_eff_q <= 1'b0;
    end else begin
      iclk_eff_q <= iclk_s ^ i_clock_sense_q;
      qclk_eff_q <= qclk_s ^ q_clock_sense_q;
    end
  end

  assign i_edge = (iclk_s ^ i_clock_sense_q) && !iclk_eff_q;
  assign q_edge = (qclk_s ^ q_clock_sense_q) && !qclk_eff_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
      tick_q <= (div_q == DIV_LAST);
    end
  end

  // Without an external clock the clock senses play no part.
  always_ff @(posedge mclk) begin
    if (reset) begin
      i_valid_q <= 1'b0;
      q_valid_q <= 1'b0;
      i_word_q  <= '0;
      q_word_q  <= '0;
    end else begin
      i_valid_q <= !serial_mode_q && (par_ext ? i_edge : tick_q);
      q_valid_q <= !serial_mode_q && (par_ext ? q_edge : tick_q);
      if (!serial_mode_q && (par_ext ? i_edge : tick_q)) begin
        i_word_q <= idat_s ^ i_data_sense_q;
      end
      if (!serial_mode_q && (par_ext ? q_edge : tick_q)) begin
        q_word_q <= qdat_s ^ q_data_sense_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial inputs
  // ----------------------------------------------------------------------
  logic [BYTE_W-1:0] link_byte;
  logic              link_tgl;
  logic              tgl_s;
  logic              tgl_seen_q;
  logic              byte_evt;

  serial_link_rx #(.BYTE_W(BYTE_W)) u_link (
    .ser_clk      (ser_clk),
    .reset        (reset),
    .ser_data_pin (ser_data_pin),
    .clk_sense    (ser_clock_sense_q),
    .byte_q       (link_byte),
    .byte_tgl_q   (link_tgl)
  );

  sync_two_ff #(.WIDTH(1)) u_tgl_sync (
    .clk      (mclk),
    .in_async (link_tgl),
    .out_sync (tgl_s)
  );

  assign byte_evt = tgl_s ^ tgl_seen_q;

  // The link byte stays stable for a whole byte time after its toggle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      tgl_seen_q  <= 1'b0;
      ser_valid_q <= 1'b0;
      ser_byte_q  <= '0;
    end else begin
      tgl_seen_q  <= tgl_s;
      ser_valid_q <= byte_evt && serial_mode_q;
      if (byte_evt && serial_mode_q) begin
        ser_byte_q <= link_byte ^ {BYTE_W{ser_data_sense_q}};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= polarity_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= polarity_pkg::READ_ZERO;
      if (reg_addr == polarity_pkg::MODE_OFS) begin
        reg_rdata_q[polarity_pkg::MODE_SERIAL_BIT] <= serial_mode_q;
        reg_rdata_q[polarity_pkg::MODE_EXTCLK_BIT] <= ext_clock_q;
      end else if (reg_addr == polarity_pkg::SENSE_OFS) begin
        reg_rdata_q[polarity_pkg::I_CLOCK_BIT]          <= i_clock_sense_q;
        reg_rdata_q[polarity_pkg::Q_CLOCK_BIT]          <= q_clock_sense_q;
        reg_rdata_q[polarity_pkg::SER_CLOCK_BIT]        <= ser_clock_sense_q;
        reg_rdata_q[polarity_pkg::SER_DATA_BIT]         <= ser_data_sense_q;
        reg_rdata_q[polarity_pkg::SER_FRAME_BIT]        <= ser_frame_sense_q;
        reg_rdata_q[polarity_pkg::I_DATA_LSB +: NIB_W]  <= i_data_sense_q;
        reg_rdata_q[polarity_pkg::Q_DATA_LSB +: NIB_W]  <= q_data_sense_q;
      end else if (reg_addr == polarity_pkg::SAMPLE_OFS) begin
        reg_rdata_q[polarity_pkg::SAMPLE_I_LSB +: NIB_W]    <= i_word_q;
        reg_rdata_q[polarity_pkg::SAMPLE_Q_LSB +: NIB_W]    <= q_word_q;
        reg_rdata_q[polarity_pkg::SAMPLE_SER_LSB +: BYTE_W] <= ser_byte_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic after_rst_q;

  always_ff @(posedge mclk) begin
    after_rst_q <= reset;
  end

  property p_i_clock_preset;
    @(posedge mclk) disable iff (reset)
      after_rst_q |-> i_clock_sense_q == polarity_pkg::SENSE_NORMAL;
  endproperty
  a_i_clock_preset: assert property (p_i_clock_preset) else $error("I clock sense not normal after reset");

  property p_q_clock_preset;
    @(posedge mclk) disable iff (reset)
      after_rst_q |-> q_clock_sense_q == polarity_pkg::SENSE_NORMAL;
  endproperty
  a_q_clock_preset: assert property (p_q_clock_preset) else $error("Q clock sense not normal after reset");

  property p_ser_preset;
    @(posedge mclk) disable iff (reset)
      after_rst_q |-> !ser_clock_sense_q && !ser_data_sense_q;
  endproperty
  a_ser_preset: assert property (p_ser_preset) else $error("Serial senses not normal after reset");

  sequence s_sense_read;
    reg_rd && !reg_wr && reg_addr == polarity_pkg::SENSE_OFS;
  endsequence

  property p_i_clock_read;
    @(posedge mclk) disable iff (reset)
      s_sense_read |=> reg_rdata_q[polarity_pkg::I_CLOCK_BIT] == $past(i_clock_sense_q);
  endproperty
  a_i_clock_read: assert property (p_i_clock_read) else $error("I clock sense read back wrong");

  property p_q_clock_read;
    @(posedge mclk) disable iff (reset)
      s_sense_read |=> reg_rdata_q[polarity_pkg::Q_CLOCK_BIT] == $past(q_clock_sense_q);
  endproperty
  a_q_clock_read: assert property (p_q_clock_read) else $error("Q clock sense read back wrong");

  property p_ser_read;
    @(posedge mclk) disable iff (reset)
      s_sense_read |=> reg_rdata_q[polarity_pkg::SER_CLOCK_BIT] == $past(ser_clock_sense_q)
                    && reg_rdata_q[polarity_pkg::SER_DATA_BIT] == $past(ser_data_sense_q);
  endproperty
  a_ser_read: assert property (p_ser_read) else $error("Serial senses read back wrong");

  sequence s_i_inv_edge;
    par_ext && i_clock_sense_q && $fell(iclk_s) && $past(i_clock_sense_q);
  endsequence

  property p_i_inverted_edge;
    @(posedge mclk) disable iff (reset)
      s_i_inv_edge ##0 $stable(i_clock_sense_q) |=> i_valid_q;
  endproperty
  a_i_inverted_edge: assert property (p_i_inverted_edge) else $error("Inverted I clock edge missed");

  property p_par_only;
    @(posedge mclk) disable iff (reset)
      (i_valid_q || q_valid_q) |-> !$past(serial_mode_q);
  endproperty
  a_par_only: assert property (p_par_only) else $error("Parallel capture in serial mode");

  property p_ser_only;
    @(posedge mclk) disable iff (reset)
      ser_valid_q |-> $past(serial_mode_q)
                   && ser_byte_q == ($past(link_byte) ^ {BYTE_W{$past(ser_data_sense_q)}});
  endproperty
  a_ser_only: assert property (p_ser_only) else $error("Serial byte wrong or outside serial mode");

  property p_global;
    @(posedge mclk) disable iff (reset)
      wr_global |=> ser_frame_sense_q == $past(gsense) && ser_data_sense_q == $past(gsense)
                 && q_data_sense_q == {NIB_W{$past(gsense)}};
  endproperty
  a_global: assert property (p_global) else $error("Global write did not reach frame sense");

  property p_global_all;
    @(posedge mclk) disable iff (reset)
      wr_global |=> i_clock_sense_q == $past(gsense) && q_clock_sense_q == $past(gsense)
                 && ser_clock_sense_q == $past(gsense) && i_data_sense_q == {NIB_W{$past(gsense)}};
  endproperty
  a_global_all: assert property (p_global_all) else $error("Global write did not set all senses");

endmodule

`default_nettype wire

/* src/polarity_pkg.sv */
// Purpose: Shared constants for the input clock and data polarity block.
// Assumes: 32-bit register port with byte addresses on word boundaries.
// Notes:   A sense bit of zero is normal and one is inverted.

package polarity_pkg;

  // ----------------------------------------------------------------------
  // Sense codes
  // ----------------------------------------------------------------------
  localparam logic SENSE_NORMAL   = 1'b0;
  localparam logic SENSE_INVERTED = 1'b1;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] SENSE_OFS  = 8'h04;
  localparam logic [7:0] GLOBAL_OFS = 8'h08;
  localparam logic [7:0] SAMPLE_OFS = 8'h0C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_SERIAL_BIT  = 0;
  localparam int MODE_EXTCLK_BIT  = 1;
  localparam int I_CLOCK_BIT      = 0;
  localparam int Q_CLOCK_BIT      = 1;
  localparam int SER_CLOCK_BIT    = 2;
  localparam int SER_DATA_BIT     = 3;
  localparam int SER_FRAME_BIT    = 4;
  localparam int I_DATA_LSB       = 8;
  localparam int Q_DATA_LSB       = 12;
  localparam int GLOBAL_SENSE_BIT = 0;
  localparam int SAMPLE_I_LSB     = 0;
  localparam int SAMPLE_Q_LSB     = 4;
  localparam int SAMPLE_SER_LSB   = 8;

  // ----------------------------------------------------------------------
  // Widths, reset values and timing counts
  // ----------------------------------------------------------------------
  localparam int          NIBBLE_W      = 4;
  localparam int          BYTE_W        = 8;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [3:0]  NIBBLE_NORMAL = 4'h0;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
  localparam int          INT_DIV       = 4;

endpackage

/* src/sync_two_ff.sv */
// Purpose: Two flip-flop synchroniser for a group of level signals.
// Assumes: Each bit is a slowly changing level or a toggle.
// Notes:   Bits of a group are not guaranteed to land in the same cycle.

`timescale 1ns/100ps
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             clk,
  // Level in and out
  input  wire logic [WIDTH-1:0] in_async,
  output logic      [WIDTH-1:0] out_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q   <= in_async;
    out_sync <= meta_q;
  end

endmodule

`default_nettype wire

/* src/serial_link_rx.sv */
// Purpose: Serial input receiver running on the serial clock pin.
// Assumes: The serial clock runs while reset is high for a few cycles.
// Notes:   An inverted clock sense samples on the falling edge.

`timescale 1ns/100ps
`default_nettype none

module serial_link_rx #(
  parameter int BYTE_W = polarity_pkg::BYTE_W
) (
  // Link clock and mclk-domain reset level
  input  wire logic              ser_clk,
  input  wire logic              reset,
  // Serial pin and clock sense from mclk domain
  input  wire logic              ser_data_pin,
  input  wire logic              clk_sense,
  // Assembled byte and its event toggle
  output logic      [BYTE_W-1:0] byte_q,
  output logic                   byte_tgl_q
);

  localparam int CNT_W = $clog2(BYTE_W);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(BYTE_W - 1);

  logic [1:0]        rst_sy_q;
  logic              sense_s;
  logic              fall_q;
  logic              bit_d;
  logic [BYTE_W-1:0] shift_q;
  logic [CNT_W-1:0]  cnt_q;

  always_ff @(posedge ser_clk) begin
    rst_sy_q <= {rst_sy_q[0], reset};
  end

  sync_two_ff #(.WIDTH(1)) u_sense_sync (
    .clk      (ser_clk),
    .in_async (clk_sense),
    .out_sync (sense_s)
  );

  // The falling-edge sample is held until the next rising edge.
  always_ff @(negedge ser_clk) begin
    fall_q <= ser_data_pin;
  end

  assign bit_d = (sense_s == polarity_pkg::SENSE_INVERTED) ? fall_q : ser_data_pin;

  always_ff @(posedge ser_clk) begin
    if (rst_sy_q[1]) begin
      shift_q    <= '0;
      cnt_q      <= '0;
      byte_q     <= '0;
      byte_tgl_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[BYTE_W-2:0], bit_d};
      cnt_q   <= (cnt_q == LAST) ? '0 : cnt_q + CNT_W'(1);
      if (cnt_q == LAST) begin
        byte_q     <= {shift_q[BYTE_W-2:0], bit_d};
        byte_tgl_q <= ~byte_tgl_q;
      end
    end
  end

endmodule

`default_nettype wire

/* verif/ext_source_model.sv */
// Purpose: Behavioural external source for the parallel and serial inputs.
// Assumes: Parallel pins move on mclk, serial bits at a 30 ns link period.
// Notes:   The link clock stands low between frames and data is valid only near the sampling edge.

`timescale 1ns/100ps
`default_nettype none

module ext_source_model (
  // Pacing clock
  input  wire logic       mclk,
  // Parallel pins
  output logic            i_clk_pin,
  output logic            q_clk_pin,
  output logic      [3:0] i_data_pin,
  output logic      [3:0] q_data_pin,
  // Serial pins
  output logic            ser_clk,
  output logic            ser_data_pin
);
  initial begin
    i_clk_pin    = 1'b0;
    q_clk_pin    = 1'b0;
    i_data_pin   = 4'h0;
    q_data_pin   = 4'h0;
    ser_clk      = 1'b0;
    ser_data_pin = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Parallel words
  // ----------------------------------------------------------------------
  // Data settles four cycles before the clock pins move, so the receiver synchronisers never race it.
  task automatic par(input logic [3:0] id, input logic [3:0] qd, input logic ic, input logic qc);
    @(posedge mclk);
    i_data_pin <= id;
    q_data_pin <= qd;
    repeat (4) @(posedge mclk);
    i_clk_pin <= ic;
    q_clk_pin <= qc;
    repeat (6) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------------
  task automatic pulses(input int n);
    repeat (n) begin
      #7.5 ser_clk = 1'b1;
      #15 ser_clk = 1'b0;
      #7.5;
    end
  endtask

  // Outside the hold window the line shows the inverse bit, so sampling on the wrong edge is seen.
  task automatic send(input logic [7:0] b, input int n, input logic sense_inverted);
    #1.3;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        if (!sense_inverted) ser_data_pin = b[i];
        #7.5 ser_clk = 1'b1;
        #1 if (sense_inverted) ser_data_pin = b[i];
        #2 if (!sense_inverted) ser_data_pin = ~b[i];
        #12 ser_clk = 1'b0;
        #3 if (sense_inverted) ser_data_pin = ~b[i];
        #4.5;
      end
    end
  endtask
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for the input clock and data polarity block.
// Assumes: One-cycle register strobes; the source model paces every pin.
// Notes:   Serial checks use repeated bytes, so a slip in bit alignment shows as a wrong byte.

`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module testbench;
  logic        mclk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata_q;
  logic        i_clk_pin, q_clk_pin, ser_clk, ser_data_pin;
  logic [3:0]  i_data_pin, q_data_pin, i_word_q, q_word_q, i_last, q_last;
  logic [7:0]  ser_byte_q, s_last;
  logic        i_valid_q, q_valid_q, ser_valid_q;
  logic [31:0] v;
  int          errors, checks, cycles, i_cnt, q_cnt, s_cnt, n0, n1;

  input_clock_data_polarity dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .i_clk_pin, .q_clk_pin, .i_data_pin, .q_data_pin, .ser_clk, .ser_data_pin, .i_word_q, .i_valid_q,
    .q_word_q, .q_valid_q, .ser_byte_q, .ser_valid_q);

  ext_source_model src (.mclk, .i_clk_pin, .q_clk_pin, .i_data_pin, .q_data_pin, .ser_clk, .ser_data_pin);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // Monitors and timeout
  // ----------------------------------------------------------------------
  // Counters update by non-blocking assignment so a test reading them at an edge sees a settled value.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (i_valid_q === 1'b1) begin
      i_cnt  <= i_cnt + 1;
      i_last <= i_word_q;
    end
    if (q_valid_q === 1'b1) begin
      q_cnt  <= q_cnt + 1;
      q_last <= q_word_q;
    end
    if (ser_valid_q === 1'b1) begin
      s_cnt  <= s_cnt + 1;
      s_last <= ser_byte_q;
    end
    if (cycles == 6000) begin
      errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata_q;
  endtask

  function automatic logic [7:0] ror1(input logic [7:0] b);
    return {b[0], b[7:1]};
  endfunction

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(polarity_pkg::MODE_OFS);
    `CHK("mode", 32'h0000_0000, v)
    rd(polarity_pkg::SENSE_OFS);
    `CHK("sense", 32'h0000_0000, v)
    rd(polarity_pkg::GLOBAL_OFS);
    `CHK("global", 32'h0000_0000, v)
    rd(8'h10);
    `CHK("unmapped", 32'h0000_0000, v)
    $display("test reset done");
  endtask

  task automatic t_readback;
    for (int b = 0; b < 4; b++) begin
      wr(polarity_pkg::SENSE_OFS, 32'h0000_0001 << b);
      rd(polarity_pkg::SENSE_OFS);
      `CHK("sense field", 32'h0000_0001 << b, v)
    end
    wr(polarity_pkg::GLOBAL_OFS, 32'h0000_0001);
    rd(polarity_pkg::SENSE_OFS);
    `CHK("global inverted", 32'h0000_FF1F, v)
    wr(polarity_pkg::GLOBAL_OFS, 32'h0000_0000);
    rd(polarity_pkg::SENSE_OFS);
    `CHK("global normal", 32'h0000_0000, v)
    $display("test readback done");
  endtask

  // The sense is written before external mode so the change itself makes no clock edge.
  task automatic t_par_ext;
    wr(polarity_pkg::SENSE_OFS, 32'h0000_0301);
    wr(polarity_pkg::MODE_OFS, 32'h0000_0002);
    repeat (8) @(posedge mclk);
    n0 = i_cnt;
    n1 = q_cnt;
    src.par(4'hA, 4'h5, 1'b1, 1'b1);
    `CHK("i no capture", 0, i_cnt - n0)
    `CHK("q capture", 1, q_cnt - n1)
    `CHK("q word", 4'h5, q_last)
    src.par(4'hC, 4'h6, 1'b0, 1'b0);
    `CHK("i capture", 1, i_cnt - n0)
    `CHK("i word", 4'hC ^ 4'h3, i_last)
    `CHK("q no capture", 1, q_cnt - n1)
    $display("test parallel external done");
  endtask

  task automatic t_par_other;
    wr(polarity_pkg::MODE_OFS, 32'h0000_0000);
    repeat (4) @(posedge mclk);
    n0 = i_cnt;
    repeat (40) @(posedge mclk);
    `CHK("internal count", 40 / polarity_pkg::INT_DIV, i_cnt - n0)
    `CHK("internal word", 4'hC ^ 4'h3, i_last)
    wr(polarity_pkg::MODE_OFS, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    n0 = i_cnt;
    n1 = q_cnt;
    src.par(4'h1, 4'h2, 1'b1, 1'b1);
    src.par(4'h3, 4'h4, 1'b0, 1'b0);
    `CHK("serial mode i", 0, i_cnt - n0)
    `CHK("serial mode q", 0, q_cnt - n1)
    $display("test parallel other modes done");
  endtask

  task automatic t_serial;
    wr(polarity_pkg::SENSE_OFS, 32'h0000_0000);
    n0 = s_cnt;
    src.send(8'hA5, 3, 1'b0);
    repeat (10) @(posedge mclk);
    `CHK("normal count", 3, s_cnt - n0)
    `CHK("normal byte", 8'hA5, s_last)
    wr(polarity_pkg::SENSE_OFS, 32'h0000_0008);
    src.send(8'h3C, 2, 1'b0);
    repeat (10) @(posedge mclk);
    `CHK("inverted data", ~8'h3C, s_last)
    wr(polarity_pkg::MODE_OFS, 32'h0000_0000);
    wr(polarity_pkg::SENSE_OFS, 32'h0000_0004);
    n0 = s_cnt;
    src.send(8'h96, 1, 1'b1);
    repeat (10) @(posedge mclk);
    `CHK("dropped outside serial", 0, s_cnt - n0)
    wr(polarity_pkg::MODE_OFS, 32'h0000_0001);
    src.send(8'h96, 2, 1'b1);
    repeat (10) @(posedge mclk);
    `CHK("inverted clock count", 2, s_cnt - n0)
    `CHK("inverted clock byte", ror1(8'h96), s_last)
    rd(polarity_pkg::SAMPLE_OFS);
    `CHK("sample word", {16'h0000, ror1(8'h96), 4'h4, 4'h3}, v)
    $display("test serial done");
  endtask

  task automatic test_done;
    $display("Totals: %0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // The link needs its clock running through reset, so reset may outlast five cycles.
  initial begin
    reset     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    fork
      repeat (5) @(posedge mclk);
      src.pulses(3);
    join
    @(posedge mclk);
    reset <= 1'b0;
    src.pulses(2);
    t_reset();
    t_readback();
    t_par_ext();
    t_par_other();
    t_serial();
    test_done();
  end
endmodule

`default_nettype wire
